// ---- src/event_action_sequencer.sv ----
// Purpose: Scan-driven event/action sequence engine of a drive
// Assumes: APB master, terminals synchronous to clock
// Notes:   Timer 0 counts in scan intervals
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "event_action_sequencer_consts.svh"

module event_action_sequencer
  import event_action_sequencer_pkg::*;
#(
  parameter int SCAN_CYCLES = `SCAN_TIME_US * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // APB slave
  input  wire logic [`ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Drive status
  input  wire logic              on_ref,
  input  wire logic              at_zero_speed,
  // Digital terminals
  input  wire logic              start_in,
  input  wire logic              stop_in,
  // Drive commands
  output logic      [15:0]       reference,
  output logic                   preset_sel,
  output logic                   motor_run,
  output logic                   ramp_down,
  output logic                   coast
);

  // Register and array storage
  logic             mode_reg;
  logic [4:0]       pair_count_reg;
  logic [23:0]      timer_preset_reg;
  logic [6:0]       preset0_reg;
  logic [6:0]       preset1_reg;
  logic [15:0]      maxref_reg;
  logic [3:0]       start_fn_reg;
  logic [3:0]       stop_fn_reg;
  code_t            event_select_array [20];
  code_t            action_select_array [20];

  // Engine state
  pair_idx_t        pair_idx_reg;
  logic [23:0]      timer_cnt_reg;
  logic             timer_expired_reg;
  logic             preset_sel_reg;
  logic [15:0]      reference_reg;
  logic [16:0]      scan_cnt_reg;
  logic             scan_tick_reg;
  logic             start_latch_reg;
  drive_state_t     drive_state_reg;
  drive_state_t     drive_state_next;
  logic             motor_run_reg;
  logic             ramp_down_reg;
  logic             coast_reg;

  // Bus state
  logic [31:0]      prdata_reg;
  logic             pready_reg;
  logic             pslverr_reg;
  logic [31:0]      rd_data;
  logic             rd_err;
  logic             wr_fire;

  // Combinational engine terms
  code_t            cur_event;
  code_t            cur_action;
  logic             event_true;
  logic             seq_active;
  logic             fire;
  logic             stop_ok;
  logic             run_req;

  // Address falls inside a 20-entry word array at base
  function automatic logic in_array(input logic [`ADDR_W-1:0] a,
                                    input logic [`ADDR_W-1:0] base);
    in_array = (a[`ADDR_W-1:7] == base[`ADDR_W-1:7]) &&
               (a[6:2] < `MAX_PAIRS) && (a[1:0] == 2'h0);
  endfunction

  // Next pair index, wrapping after the last programmed pair
  function automatic pair_idx_t wrap_next(input pair_idx_t idx,
                                          input logic [4:0] cnt);
    if (idx + 5'h01 >= cnt) begin
      wrap_next = 5'h00;
    end else begin
      wrap_next = idx + 5'h01;
    end
  endfunction

  // Percent of maximum reference
  function automatic logic [15:0] scale(input logic [6:0] pct,
                                        input logic [15:0] maxref);
    logic [22:0] prod;
    prod = {16'h0000, pct} * {7'h00, maxref};
    scale = 16'(prod / {16'h0000, `PCT_FULL});
  endfunction

  // Drive outputs straight from flops
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign reference  = reference_reg;
  assign preset_sel = preset_sel_reg;
  assign motor_run  = motor_run_reg;
  assign ramp_down  = ramp_down_reg;
  assign coast      = coast_reg;

  // Read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (in_array(paddr, `OFF_EVENT_BASE)) begin
      rd_data = {24'h000000, event_select_array[paddr[6:2]]};
    end else if (in_array(paddr, `OFF_ACTION_BASE)) begin
      rd_data = {24'h000000, action_select_array[paddr[6:2]]};
    end else begin
      case (paddr)
        `OFF_MODE:    rd_data = {31'h0, mode_reg};
        `OFF_COUNT:   rd_data = {27'h0, pair_count_reg};
        `OFF_TIMER:   rd_data = {8'h00, timer_preset_reg};
        `OFF_PRESET0: rd_data = {25'h0, preset0_reg};
        `OFF_PRESET1: rd_data = {25'h0, preset1_reg};
        `OFF_MAXREF:  rd_data = {16'h0000, maxref_reg};
        `OFF_INFUNC:  rd_data = {24'h000000, stop_fn_reg, start_fn_reg};
        `OFF_STATUS:  rd_data = {reference_reg, 3'h0, coast_reg,
                                 ramp_down_reg, motor_run_reg,
                                 timer_expired_reg, preset_sel_reg,
                                 3'h0, pair_idx_reg};
        default:      rd_err = 1'b1;
      endcase
    end
  end

  // Write lands at the edge that completes the access
  assign wr_fire = psel && penable && pwrite && pready_reg && !rd_err;

  // APB handshake, one wait state
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (psel && penable && !pready_reg) begin
      pready_reg  <= 1'b1;
      prdata_reg  <= pwrite ? 32'h0000_0000 : (rd_err ? 32'h0 : rd_data);
      pslverr_reg <= rd_err;
    end else begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_reg         <= 1'b0;
      pair_count_reg   <= 5'h00;
      timer_preset_reg <= 24'h000000;
      preset0_reg      <= 7'h00;
      preset1_reg      <= 7'h00;
      maxref_reg       <= `RST_MAXREF;
      start_fn_reg     <= `RST_START_FN;
      stop_fn_reg      <= `RST_STOP_FN;
    end else if (wr_fire) begin
      case (paddr)
        `OFF_MODE:    mode_reg <= pwdata[0];
        `OFF_COUNT: begin
          // Counts above the array size clamp to it
          if (pwdata[4:0] > `MAX_PAIRS || pwdata[31:5] != 27'h0) begin
            pair_count_reg <= `MAX_PAIRS;
          end else begin
            pair_count_reg <= pwdata[4:0];
          end
        end
        `OFF_TIMER:   timer_preset_reg <= pwdata[23:0];
        `OFF_PRESET0: preset0_reg <= pwdata[6:0];
        `OFF_PRESET1: preset1_reg <= pwdata[6:0];
        `OFF_MAXREF:  maxref_reg <= pwdata[15:0];
        `OFF_INFUNC: begin
          start_fn_reg <= pwdata[3:0];
          stop_fn_reg  <= pwdata[7:4];
        end
        default: ;
      endcase
    end
  end

  // Event and action arrays, one word per pair
  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < 20; i++) begin
        event_select_array[i]  <= `EV_FALSE;
        action_select_array[i] <= `ACT_NONE;
      end
    end else if (wr_fire && in_array(paddr, `OFF_EVENT_BASE)) begin
      event_select_array[paddr[6:2]] <= pwdata[7:0];
    end else if (wr_fire && in_array(paddr, `OFF_ACTION_BASE)) begin
      action_select_array[paddr[6:2]] <= pwdata[7:0];
    end
  end

  // Scan interval divider
  always_ff @(posedge clock) begin
    if (!nrst || scan_cnt_reg == 17'(SCAN_CYCLES - 1)) begin
      scan_cnt_reg <= 17'h00000;
    end else begin
      scan_cnt_reg <= scan_cnt_reg + 17'h00001;
    end
  end

  // One-cycle scan tick
  always_ff @(posedge clock) begin
    if (!nrst) begin
      scan_tick_reg <= 1'b0;
    end else begin
      scan_tick_reg <= (scan_cnt_reg == 17'(SCAN_CYCLES - 1));
    end
  end

  // Only the current pair is looked at
  assign cur_event  = event_select_array[pair_idx_reg];
  assign cur_action = action_select_array[pair_idx_reg];

  // Event code evaluation, unknown codes read false
  always_comb begin
    case (cur_event)
      `EV_FALSE:    event_true = 1'b0;
      `EV_TRUE:     event_true = 1'b1;
      `EV_ON_REF:   event_true = on_ref;
      `EV_TIMEOUT0: event_true = timer_expired_reg;
      default:      event_true = 1'b0;
    endcase
  end

  // Engine runs with mode on and at least one pair
  assign seq_active = mode_reg && (pair_count_reg != 5'h00);
  assign fire = scan_tick_reg && seq_active && event_true &&
                (pair_idx_reg < pair_count_reg);

  // Pair index; stays put while the event is false
  always_ff @(posedge clock) begin
    if (!nrst || !mode_reg) begin
      pair_idx_reg <= 5'h00;
    end else if (scan_tick_reg && seq_active) begin
      if (pair_idx_reg >= pair_count_reg) begin
        pair_idx_reg <= 5'h00;
      end else if (event_true) begin
        pair_idx_reg <= wrap_next(pair_idx_reg, pair_count_reg);
      end
    end
  end

  // Preset selection actions
  always_ff @(posedge clock) begin
    if (!nrst) begin
      preset_sel_reg <= 1'b0;
    end else if (fire && cur_action == `ACT_PRESET0) begin
      preset_sel_reg <= 1'b0;
    end else if (fire && cur_action == `ACT_PRESET1) begin
      preset_sel_reg <= 1'b1;
    end
  end

  // Timer 0, counted in scan intervals
  always_ff @(posedge clock) begin
    if (!nrst || !mode_reg) begin
      timer_cnt_reg     <= 24'h000000;
      timer_expired_reg <= 1'b0;
    end else if (fire && cur_action == `ACT_TIMER0) begin
      timer_cnt_reg     <= timer_preset_reg;
      timer_expired_reg <= (timer_preset_reg == 24'h000000);
    end else if (scan_tick_reg && timer_cnt_reg != 24'h000000) begin
      timer_cnt_reg <= timer_cnt_reg - 24'h000001;
      if (timer_cnt_reg == 24'h000001) begin
        timer_expired_reg <= 1'b1;
      end
    end
  end

  // Reference as percent of maximum
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reference_reg <= 16'h0000;
    end else begin
      reference_reg <= scale(preset_sel_reg ? preset1_reg : preset0_reg,
                             maxref_reg);
    end
  end

  // Stop input, low active when so configured
  assign stop_ok = (stop_fn_reg == `IN_STOP_INV) ? stop_in : 1'b1;

  // Latched start held after the pulse, cleared by stop
  always_ff @(posedge clock) begin
    if (!nrst) begin
      start_latch_reg <= 1'b0;
    end else if (!stop_ok || start_fn_reg != `IN_LATCH_START) begin
      start_latch_reg <= 1'b0;
    end else if (start_in) begin
      start_latch_reg <= 1'b1;
    end
  end

  // Run request from level or latched start
  assign run_req = stop_ok &&
                   ((start_fn_reg == `IN_START && start_in) ||
                    start_latch_reg);

  // Drive state: run, ramp down, free
  always_comb begin
    drive_state_next = drive_state_reg;
    unique case (drive_state_reg)
      DRIVE_FREE: begin
        if (run_req) begin
          drive_state_next = DRIVE_RUN;
        end
      end
      DRIVE_RUN: begin
        if (!run_req) begin
          drive_state_next = DRIVE_RAMP;
        end
      end
      DRIVE_RAMP: begin
        if (run_req) begin
          drive_state_next = DRIVE_RUN;
        end else if (at_zero_speed) begin
          drive_state_next = DRIVE_FREE;
        end
      end
    endcase
  end

  // Drive state and its output flops
  always_ff @(posedge clock) begin
    if (!nrst) begin
      drive_state_reg <= DRIVE_FREE;
      motor_run_reg   <= 1'b0;
      ramp_down_reg   <= 1'b0;
      coast_reg       <= 1'b1;
    end else begin
      drive_state_reg <= drive_state_next;
      motor_run_reg   <= (drive_state_next == DRIVE_RUN);
      ramp_down_reg   <= (drive_state_next == DRIVE_RAMP);
      coast_reg       <= (drive_state_next == DRIVE_FREE);
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence live_tick_s;
    scan_tick_reg && seq_active && pair_idx_reg < pair_count_reg;
  endsequence

  sequence fire_s;
    live_tick_s ##0 event_true;
  endsequence

  idx_advance_a: assert property (
    fire_s |=> pair_idx_reg == wrap_next($past(pair_idx_reg),
                                         $past(pair_count_reg)))
    else $error("pair index did not advance after a true event");

  idx_wrap_a: assert property (
    fire_s ##0 (pair_idx_reg + 5'h01 == pair_count_reg) |=>
      pair_idx_reg == 5'h00)
    else $error("sequence did not wrap to the first pair");

  false_hold_a: assert property (
    live_tick_s ##0 !event_true && mode_reg |=> $stable(pair_idx_reg) &&
      $stable(preset_sel_reg))
    else $error("false event changed sequencer state");

  no_tick_a: assert property (
    !scan_tick_reg && mode_reg |=> $stable(pair_idx_reg))
    else $error("pair index moved without a scan tick");

  mode_off_a: assert property (
    !mode_reg |=> pair_idx_reg == 5'h00 && !timer_expired_reg)
    else $error("sequencer not reset with mode off");

  zero_idle_a: assert property (
    pair_count_reg == 5'h00 && mode_reg |=> $stable(preset_sel_reg) &&
      $stable(pair_idx_reg))
    else $error("action fired with zero pairs");

  only_true_a: assert property (
    !(scan_tick_reg && seq_active && event_true) |=> $stable(preset_sel_reg))
    else $error("action fired without a true event");

  preset_pick_a: assert property (
    fire_s ##0 cur_action == `ACT_PRESET1 |=> preset_sel_reg ##2
      reference_reg == scale(preset1_reg, maxref_reg))
    else $error("preset 1 not selected or scaled");

  timer_load_a: assert property (
    fire_s ##0 cur_action == `ACT_TIMER0 |=>
      timer_cnt_reg == $past(timer_preset_reg))
    else $error("timer 0 not loaded with its preset");

  timer_end_a: assert property (
    scan_tick_reg && timer_cnt_reg == 24'h000001 && mode_reg &&
      !fire |=> timer_expired_reg)
    else $error("timer 0 expiry not flagged");

  stop_ramp_a: assert property (
    drive_state_reg == DRIVE_RUN && !run_req |=> ramp_down_reg ##0
      !motor_run_reg)
    else $error("stop did not start a ramp down");

  stop_clear_a: assert property (
    stop_fn_reg == `IN_STOP_INV && !stop_in |=> !start_latch_reg)
    else $error("stop did not clear the latched start");

  latch_keep_a: assert property (
    start_latch_reg && start_fn_reg == `IN_LATCH_START && stop_ok |=>
      start_latch_reg)
    else $error("latched start dropped without a stop");

endmodule // event_action_sequencer
`default_nettype wire

// ---- src/event_action_sequencer_consts.svh ----
// Purpose: Constants of the event/action sequencer
// Assumes: 100 MHz clock, APB slave with 32-bit data
// Notes:   Event, action and input function codes are the drive's
// Summary of operation
// - An action runs only when its paired event is true.
// - Event n true runs action n, then event n+1 is watched.
// - After an action only the next event is evaluated.
// - A false event means nothing happens this scan interval.
// - On start only event 1 is evaluated, each scan interval.
// - Pair count is programmable from 0 to 20.
// - After the last pair the sequence wraps to pair 1.
// - Events and actions live in arrays, one entry per pair.
// - Event codes: 0 false, 1 true, 4 on reference, 30 timeout 0.
// - Action 10 selects preset 0, action 11 selects preset 1.
// - Action 29 starts timer 0, action 1 does nothing.
// - Timer 0 loads a set duration; expiry makes timeout 0 true.
// - The sequencer runs only while its mode is on.
// - Preset references are percentages of the maximum reference.
// - Stop ramps the drive down, then lets it run free.
// - Input code 8 is level start, code 0 does nothing.
// - Input code 9 is latched start, kept after the pulse.
// - Input code 6 is stop, low active, clearing a latched start.
`ifndef EVENT_ACTION_SEQUENCER_CONSTS_SVH
`define EVENT_ACTION_SEQUENCER_CONSTS_SVH
`define CLK_MHZ         100
`define SCAN_TIME_US    1000
`define MAX_PAIRS       5'h14
`define ADDR_W          12
`define OFF_MODE        12'h000
`define OFF_COUNT       12'h004
`define OFF_TIMER       12'h008
`define OFF_PRESET0     12'h00C
`define OFF_PRESET1     12'h010
`define OFF_MAXREF      12'h014
`define OFF_INFUNC      12'h018
`define OFF_STATUS      12'h01C
`define OFF_EVENT_BASE  12'h100
`define OFF_ACTION_BASE 12'h180
`define EV_FALSE        8'h00
`define EV_TRUE         8'h01
`define EV_ON_REF       8'h04
`define EV_TIMEOUT0     8'h1E
`define ACT_NONE        8'h01
`define ACT_PRESET0     8'h0A
`define ACT_PRESET1     8'h0B
`define ACT_TIMER0      8'h1D
`define IN_NOP          4'h0
`define IN_STOP_INV     4'h6
`define IN_START        4'h8
`define IN_LATCH_START  4'h9
`define PCT_FULL        7'h64
`define RST_MAXREF      16'h05DC
`define RST_START_FN    4'h8
`define RST_STOP_FN     4'h0
`endif

// ---- src/event_action_sequencer_pkg.sv ----
// Purpose: Types of the event/action sequencer
// Assumes: Constants come from the _consts header
// Notes:   Types only
package event_action_sequencer_pkg;
  typedef enum logic [1:0] {DRIVE_FREE, DRIVE_RUN, DRIVE_RAMP} drive_state_t;
  typedef logic [7:0] code_t;
  typedef logic [4:0] pair_idx_t;
endpackage

// ---- bench/drive_plant.sv ----
// Purpose: Behavioural motor and load behind the drive outputs
// Assumes: Speed moves one step a clock while driven or ramping
// Notes:   LAG sets the clocks needed to reach reference or standstill
`timescale 1ns/1ps
`default_nettype none

module drive_plant #(
  parameter int LAG = 5
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // Drive commands
  input  wire logic motor_run,
  input  wire logic ramp_down,
  // Drive status
  output logic      on_ref,
  output logic      at_zero_speed
);
  int speed;

  // Shaft speed follows run and ramp commands
  always_ff @(posedge clock) begin
    if (!nrst) speed <= 0;
    else if (motor_run && speed < LAG) speed <= speed + 1;
    else if (ramp_down && speed > 0) speed <= speed - 1;
  end

  // Status seen by the drive's event logic and drive state machine
  assign on_ref        = motor_run && speed == LAG;
  assign at_zero_speed = ramp_down && speed == 0;
endmodule // drive_plant
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: Self-checking bench for the event/action sequencer
// Assumes: Scan interval shortened to 16 clocks
// Notes:   Plant model answers run and ramp commands
`timescale 1ns/1ps
`default_nettype none
`include "event_action_sequencer_consts.svh"

module tb
  import event_action_sequencer_pkg::*;
;
  localparam int SCAN = 16;
  logic               clock, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic               on_ref, at_zero_speed, start_in, stop_in;
  logic               preset_sel, motor_run, ramp_down, coast, exp_sel;
  logic [15:0]        reference, maxref;
  logic [6:0]         pct0, pct1;
  code_t              ev [20];
  code_t              ac [20];
  int                 err_total, checked, seed, cnt, p, n;
  logic [11:0]        ra [9] = '{`OFF_MODE, `OFF_COUNT, `OFF_MAXREF, `OFF_INFUNC,
    `OFF_STATUS, `OFF_EVENT_BASE, `OFF_ACTION_BASE + 12'h04C, 12'h040, 12'h002};
  logic [31:0]        rv [9] = '{32'h0, 32'h0, 32'h05DC, 32'h08, 32'h1000, 32'h0,
    32'h1, 32'h0, 32'h0};

  // Device with a short scan interval
  event_action_sequencer #(.SCAN_CYCLES(SCAN)) u_dut (
    .clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .on_ref(on_ref), .at_zero_speed(at_zero_speed),
    .start_in(start_in), .stop_in(stop_in), .reference(reference),
    .preset_sel(preset_sel), .motor_run(motor_run), .ramp_down(ramp_down),
    .coast(coast));

  // Motor and load
  drive_plant #(.LAG(5)) u_plant (.clock(clock), .nrst(nrst), .motor_run(motor_run),
    .ramp_down(ramp_down), .on_ref(on_ref), .at_zero_speed(at_zero_speed));

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Verdict and end of run
  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      err_total++;
    end
  endtask

  // Run state outputs as one value
  task automatic cmp3(input logic [2:0] exp, input string what);
    cmp(32'({motor_run, ramp_down, coast}), 32'(exp), what);
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    // Ready, data and error are taken at the completing rising edge
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 40);
    if (k >= 40) begin
      cmp(32'h0, 32'h1, "apb timeout");
      tally_and_finish();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read with expected data and error flag
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp, "read data");
    cmp(32'(err), 32'(e), "read error");
  endtask

  // Expected reference for a preset percentage
  function automatic logic [15:0] scale(input logic [6:0] pct);
    return 16'((32'(pct) * 32'(maxref)) / 100);
  endfunction

  // Two-clock reset, terminals idle
  task automatic do_reset;
    @(posedge clock);
    nrst     <= 1'b0;
    start_in <= 1'b0;
    stop_in  <= 1'b1;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
  endtask

  // Let n edges pass, then sample mid-cycle
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    @(negedge clock);
  endtask

  // Presets, whole pair table, count, then mode on
  task automatic load_pairs(input int c, input logic [23:0] tmr);
    apb(1'b1, `OFF_MAXREF, {16'h0, maxref});
    apb(1'b1, `OFF_PRESET0, {25'h0, pct0});
    apb(1'b1, `OFF_PRESET1, {25'h0, pct1});
    apb(1'b1, `OFF_TIMER, {8'h0, tmr});
    for (int k = 0; k < 20; k++) begin
      apb(1'b1, `OFF_EVENT_BASE + 12'(4 * k), {24'h0, ev[k]});
      apb(1'b1, `OFF_ACTION_BASE + 12'(4 * k), {24'h0, ac[k]});
    end
    apb(1'b1, `OFF_COUNT, 32'(c));
    apb(1'b1, `OFF_MODE, 32'h1);
  endtask

  // Main sequence
  initial begin
    nrst      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = 32'h0;
    start_in  = 1'b0;
    stop_in   = 1'b1;
    err_total = 0;
    checked   = 0;
    seed      = 48;
    maxref    = 16'h05DC;
    pct0      = 7'h00;
    pct1      = 7'h00;
    foreach (ev[k]) ev[k] = `EV_FALSE;
    foreach (ac[k]) ac[k] = `ACT_NONE;
    do_reset();
    settle(0);
    cmp(32'({reference, coast, preset_sel, motor_run, ramp_down}), 32'h8, "reset");
    foreach (ra[k]) rchk(ra[k], rv[k], k > 6);
    apb(1'b1, 12'h040, 32'h1);
    cmp(32'(err), 32'h1, "unmapped write");
    apb(1'b1, `OFF_STATUS, 32'hFFFF_FFFF);
    rchk(`OFF_STATUS, 32'h1000, 1'b0);
    apb(1'b1, `OFF_COUNT, 32'h1F);
    rchk(`OFF_COUNT, 32'h14, 1'b0);
    // Idle with zero count, with mode off, then running
    ev[0] = `EV_TRUE;
    ac[0] = `ACT_PRESET1;
    load_pairs(0, 24'h0);
    settle(3 * SCAN);
    cmp(32'(preset_sel), 32'h0, "count zero");
    apb(1'b1, `OFF_MODE, 32'h0);
    apb(1'b1, `OFF_COUNT, 32'h1);
    settle(3 * SCAN);
    cmp(32'(preset_sel), 32'h0, "mode off");
    apb(1'b1, `OFF_MODE, 32'h1);
    settle(2 * SCAN + 2);
    cmp(32'(preset_sel), 32'h1, "mode on");
    // Random tables that block at one false event
    repeat (4) begin
      do_reset();
      maxref  = 16'($random(seed));
      pct0    = 7'($unsigned($random(seed)) % 101);
      pct1    = 7'($unsigned($random(seed)) % 101);
      cnt     = 2 + $unsigned($random(seed)) % 7;
      p       = $unsigned($random(seed)) % cnt;
      exp_sel = 1'b0;
      for (n = 0; n < 20; n++) begin
        ev[n] = (n == p) ? `EV_FALSE : `EV_TRUE;
        case ($unsigned($random(seed)) % 3)
          0: ac[n] = `ACT_NONE;
          1: ac[n] = `ACT_PRESET0;
          default: ac[n] = `ACT_PRESET1;
        endcase
        if (n < p && ac[n] != `ACT_NONE) exp_sel = (ac[n] == `ACT_PRESET1);
      end
      load_pairs(cnt, 24'h0);
      settle((cnt + 3) * SCAN);
      rchk(`OFF_STATUS, {scale(exp_sel ? pct1 : pct0), 7'h08, exp_sel, 3'h0, 5'(p)}, 1'b0);
    end
    // Two pairs toggling the preset, one per scan tick
    do_reset();
    ev[0] = `EV_TRUE;
    ev[1] = `EV_TRUE;
    ac[0] = `ACT_PRESET1;
    ac[1] = `ACT_PRESET0;
    load_pairs(2, 24'h0);
    n = 0;
    while (preset_sel !== 1'b1 && n < 3 * SCAN) begin
      @(negedge clock);
      n++;
    end
    cmp(32'(preset_sel), 32'h1, "first pair");
    if (preset_sel !== 1'b1) tally_and_finish();
    exp_sel = 1'b1;
    repeat (4) begin
      repeat (SCAN - 1) @(negedge clock);
      cmp(32'(preset_sel), 32'(exp_sel), "between ticks");
      @(negedge clock);
      exp_sel = ~exp_sel;
      cmp(32'(preset_sel), 32'(exp_sel), "wrapped pair");
    end
    apb(1'b1, `OFF_EVENT_BASE + 12'h004, 32'h0);
    settle(3 * SCAN);
    apb(1'b0, `OFF_STATUS, 32'h0);
    cmp(32'(rd[4:0]), 32'h1, "held index");
    apb(1'b1, `OFF_MODE, 32'h0);
    apb(1'b0, `OFF_STATUS, 32'h0);
    cmp(32'(rd[4:0]), 32'h0, "index cleared");
    // Preset, on reference, timer and start sequence
    do_reset();
    maxref = 16'($random(seed));
    pct0   = 7'h3C;
    pct1   = 7'h00;
    ev[0] = `EV_TRUE;
    ev[1] = `EV_ON_REF;
    ev[2] = `EV_TIMEOUT0;
    ev[3] = `EV_FALSE;
    ac[0] = `ACT_PRESET0;
    ac[1] = `ACT_TIMER0;
    ac[2] = `ACT_PRESET1;
    ac[3] = `ACT_NONE;
    load_pairs(4, 24'h6);
    settle(4 * SCAN);
    rchk(`OFF_STATUS, {scale(pct0), 7'h08, 1'b0, 3'h0, 5'h01}, 1'b0);
    @(posedge clock);
    start_in <= 1'b1;
    settle(3 * SCAN);
    rchk(`OFF_STATUS, {scale(pct0), 7'h02, 1'b0, 3'h0, 5'h02}, 1'b0);
    cmp(32'(reference), 32'(scale(pct0)), "reference pin");
    settle(8 * SCAN);
    rchk(`OFF_STATUS, {16'h0, 7'h03, 1'b1, 3'h0, 5'h03}, 1'b0);
    // Level start with stop terminal unused
    @(posedge clock);
    stop_in <= 1'b0;
    settle(4);
    cmp3(3'b100, "stop unused");
    @(posedge clock);
    start_in <= 1'b0;
    settle(2);
    cmp3(3'b010, "ramping");
    settle(10);
    cmp3(3'b001, "free");
    // Latched start and inverted stop
    apb(1'b1, `OFF_INFUNC, 32'h69);
    @(posedge clock);
    stop_in  <= 1'b1;
    start_in <= 1'b1;
    @(posedge clock);
    start_in <= 1'b0;
    settle(6);
    cmp3(3'b100, "latched run");
    @(posedge clock);
    stop_in <= 1'b0;
    settle(2);
    cmp3(3'b010, "stop ramp");
    @(posedge clock);
    stop_in <= 1'b1;
    settle(12);
    cmp3(3'b001, "latch cleared");
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
